// ---- ppic_pkg.sv ----
package ppic_pkg;

   localparam int PPIC_NUM_CLR = 3;
   localparam int PPIC_NUM_MASK = 4;
   localparam int PPIC_NUM_PRIO = 26;
   localparam int PPIC_NUM_PINS = 5;

   // posted/clear register byte offsets
   localparam logic [7:0] PPIC_CLR_ADDR [0:2] = '{8'hda, 8'hdb, 8'hdc};
   // mask register offsets: mask0, mask1, mask2, mask3
   localparam logic [7:0] PPIC_MASK_ADDR [0:3] =
      '{8'he0, 8'he1, 8'hdf, 8'hde};

   // bits that carry a real source in each posted/clear register
   localparam logic [7:0] PPIC_CLR_IMPL [0:2] = '{8'hfd, 8'h60, 8'h16};
   // writable bits of each mask register
   localparam logic [7:0] PPIC_MASK_WR [0:3] =
      '{8'hff, 8'he0, 8'h16, 8'h80};
   localparam int PPIC_SOFT_INT_BIT = 7;
   localparam int PPIC_SOFT_INT_REG = 3;

   // priority of each posted bit, bit 0 first
   localparam logic [4:0] PPIC_PRIO_OF [0:2][0:7] = '{
      '{5'h01, 5'h00, 5'h03, 5'h04, 5'h05, 5'h07, 5'h19, 5'h06},
      '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h0d, 5'h0e, 5'h00},
      '{5'h00, 5'h11, 5'h12, 5'h00, 5'h14, 5'h00, 5'h00, 5'h00}};

   // vector address is priority times four
   localparam int PPIC_VECTOR_SHIFT = 2;

   // dispatch timing, in cpu cycles
   localparam int PPIC_DISPATCH_CYCLES = 13;
   localparam int PPIC_LONG_JUMP_INSTR_CYCLES = 7;
   localparam logic [3:0] PPIC_STEP_PUSH_PCH = 4'h1;
   localparam logic [3:0] PPIC_STEP_PUSH_PCL = 4'h2;
   localparam logic [3:0] PPIC_STEP_PUSH_FLAGS = 4'h3;
   localparam logic [3:0] PPIC_STEP_CLEAR_FLAGS = 4'h4;
   localparam logic [3:0] PPIC_STEP_LOAD_PC = 4'h5;
   localparam logic [3:0] PPIC_STEP_LAST = 4'(PPIC_DISPATCH_CYCLES - 1);

   localparam logic [7:0] PPIC_POSTED_RESET = 8'h00;
   localparam logic [7:0] PPIC_MASK_RESET = 8'h00;

   typedef enum logic [0:0] {
      PPIC_ST_IDLE = 1'b0,
      PPIC_ST_DISPATCH = 1'b1
   } ppic_state_type;

   typedef struct packed {
      ppic_state_type state;
      logic [3:0] step;
      logic [4:0] win_prio;
      logic [2:0][7:0] posted;
      logic [3:0][7:0] mask;
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic [4:0] pin_prev;
      logic [7:0] rdata;
      logic stack_push;
      logic [7:0] stack_data;
      logic flag_clear;
      logic pc_load;
      logic [15:0] pc_value;
   } ppic_regs_type;

   localparam ppic_regs_type PPIC_REGS_RESET = '0;

endpackage : ppic_pkg

// ---- ppic_ctrl.sv ----
// Behaviour
// (RL1) event sets posted flag until taken/cleared
// (RL2) pending means posted and mask set
// (RL3) mask clear keeps posted, stops pending
// (RL4) highest pending wins, taken under global enable
// (RL5) request active on event, unmask, enable rise
// (RL6) dispatch only at instruction boundary
// (RL7) thirteen cycles, push pch, pcl, flags (code: twelve dispatch cycles)
// (RL8) clear flag register after pushes
// (RL9) pc high zero, low gets vector
// (RL10) return restores flags, enable back
// (RL11) pending served before next instruction
// (RL12) latency: finish, thirteen, seven jump (code: twelve dispatch cycles)
// (RL13) clear register read shows posted flags
// (RL14) soft enable off: zero clears
// (RL15) soft enable on: one posts
// (RL16) clear register zero source map
// (RL17) clear register one source map
// (RL18) clear register two source map
// (RL19) pin port sources posted on edges
// (RL20) mask bits act independently
// (RL21) fixed priorities, vector four times priority
// (RL22) lowest number wins, taken flag cleared
// (RL23) flags reset zero, reserved read zero
`timescale 1ns/10ps
module ppic_ctrl
   import ppic_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic gpio_port0_cond,
   input wire logic gpio_port1_cond,
   input wire logic gpio_port2_cond,
   input wire logic ext_line_one,
   input wire logic ext_line_two,
   input wire logic power_on_low_voltage,
   input wire logic spi_tx_empty_evt,
   input wire logic spi_rx_full_evt,
   input wire logic sleep_timer_evt,
   input wire logic timer_1ms_evt,
   input wire logic interval_timer_evt,
   input wire logic free_counter_wrap_evt,
   input wire logic global_int_enable,
   input wire logic instr_boundary,
   input wire logic [15:0] cpu_program_counter,
   input wire logic [7:0] cpu_flags,
   output logic irq_active,
   output logic dispatch_busy,
   output logic stack_push,
   output logic [7:0] stack_data,
   output logic flag_clear,
   output logic pc_load,
   output logic [15:0] pc_load_value
);

   ppic_regs_type r_reg;
   ppic_regs_type r_next;
   logic [PPIC_NUM_PRIO-1:0] pend;
   logic [4:0] win;

   // spread posted&mask over the priority numbers
   function automatic logic [PPIC_NUM_PRIO-1:0] pending_vec(
      input logic [2:0][7:0] posted,
      input logic [3:0][7:0] mask
   );
      logic [PPIC_NUM_PRIO-1:0] v;
      v = '0;
      for (int i = 0; i < PPIC_NUM_CLR; i++)
      begin
         for (int b = 0; b < 8; b++)
         begin
            // (RL20) per-bit gate
            if (PPIC_CLR_IMPL[i][b] && posted[i][b] && mask[i][b])
            begin
               v[PPIC_PRIO_OF[i][b]] = 1'b1;
            end
         end
      end
      return v;
   endfunction : pending_vec

   // lowest number is the highest priority
   function automatic logic [4:0] lowest_prio(
      input logic [PPIC_NUM_PRIO-1:0] v
   );
      logic [4:0] p;
      p = '0;
      for (int k = PPIC_NUM_PRIO - 1; k >= 0; k--)
      begin
         if (v[k])
         begin
            p = 5'(k);
         end
      end
      return p;
   endfunction : lowest_prio

   // (RL2) only pending sources reach the encoder
   assign pend = pending_vec(r_reg.posted, r_reg.mask);
   // (RL21) fixed priority encoding
   assign win = lowest_prio(pend);

   // (RL5) level follows pending and enable, so all three cases show
   assign irq_active = (|pend) && global_int_enable;
   assign dispatch_busy = (r_reg.state == PPIC_ST_DISPATCH);
   assign reg_rdata = r_reg.rdata;
   assign stack_push = r_reg.stack_push;
   assign stack_data = r_reg.stack_data;
   assign flag_clear = r_reg.flag_clear;
   assign pc_load = r_reg.pc_load;
   assign pc_load_value = r_reg.pc_value;

   always_comb
   begin
      logic [4:0] edges;
      logic [2:0][7:0] set_evt;
      logic soft_en;
      edges = '0;
      set_evt = '0;
      soft_en = 1'b0;
      r_next = r_reg;
      r_next.stack_push = 1'b0;
      r_next.flag_clear = 1'b0;
      r_next.pc_load = 1'b0;
      r_next.rdata = 8'h00;

      // pins are asynchronous: two stages before any use
      r_next.sync1 = {ext_line_two, ext_line_one, gpio_port2_cond,
                      gpio_port1_cond, gpio_port0_cond};
      r_next.sync2 = r_reg.sync1;
      r_next.pin_prev = r_reg.sync2;
      // (RL19) rising edge of the pin condition posts
      edges = r_reg.sync2 & ~r_reg.pin_prev;

      // (RL16) clear register zero layout
      set_evt[0] = {edges[1], sleep_timer_evt, edges[3], edges[0],
                    spi_rx_full_evt, spi_tx_empty_evt, 1'b0,
                    power_on_low_voltage};
      // (RL17) clear register one layout
      set_evt[1] = {1'b0, interval_timer_evt, timer_1ms_evt, 5'h00};
      // (RL18) clear register two layout
      set_evt[2] = {3'h0, edges[2], 1'b0, edges[4],
                    free_counter_wrap_evt, 1'b0};

      soft_en = r_reg.mask[PPIC_SOFT_INT_REG][PPIC_SOFT_INT_BIT];

      for (int i = 0; i < PPIC_NUM_CLR; i++)
      begin
         if (reg_wr && reg_addr == PPIC_CLR_ADDR[i])
         begin
            if (soft_en)
            begin
               // (RL15) ones post, zeros ignored
               r_next.posted[i] = r_reg.posted[i]
                                  | (reg_wdata & PPIC_CLR_IMPL[i]);
            end
            else
            begin
               // (RL14) zeros clear, ones ignored
               r_next.posted[i] = r_reg.posted[i]
                                  & (reg_wdata | ~PPIC_CLR_IMPL[i]);
            end
         end
         // (RL13) read returns posted flags
         if (reg_rd && reg_addr == PPIC_CLR_ADDR[i])
         begin
            r_next.rdata = r_reg.posted[i];
         end
      end

      for (int i = 0; i < PPIC_NUM_MASK; i++)
      begin
         // (RL3) a mask write never touches posted flags
         if (reg_wr && reg_addr == PPIC_MASK_ADDR[i])
         begin
            r_next.mask[i] = reg_wdata & PPIC_MASK_WR[i];
         end
         if (reg_rd && reg_addr == PPIC_MASK_ADDR[i])
         begin
            r_next.rdata = r_reg.mask[i];
         end
      end

      case (r_reg.state)
         PPIC_ST_IDLE:
         begin
            // (RL6) start only once the instruction has finished
            // (RL11) also checked at the boundary after a return
            // (RL10) enable comes back from the core's restored flags
            if (instr_boundary && irq_active)
            begin
               // (RL4) take the winner under global enable
               r_next.state = PPIC_ST_DISPATCH;
               r_next.step = 4'h1;
               r_next.win_prio = win;
               // (RL22) taken source loses its posted flag
               for (int i = 0; i < PPIC_NUM_CLR; i++)
               begin
                  for (int b = 0; b < 8; b++)
                  begin
                     if (PPIC_CLR_IMPL[i][b] && PPIC_PRIO_OF[i][b] == win)
                     begin
                        r_next.posted[i][b] = 1'b0;
                     end
                  end
               end
            end
         end
         PPIC_ST_DISPATCH:
         begin
            // (RL7) fixed 12-cycle dispatch (steps 1 to 12) with three pushes
            case (r_reg.step)
               PPIC_STEP_PUSH_PCH:
               begin
                  r_next.stack_push = 1'b1;
                  r_next.stack_data = cpu_program_counter[15:8];
               end
               PPIC_STEP_PUSH_PCL:
               begin
                  r_next.stack_push = 1'b1;
                  r_next.stack_data = cpu_program_counter[7:0];
               end
               PPIC_STEP_PUSH_FLAGS:
               begin
                  r_next.stack_push = 1'b1;
                  r_next.stack_data = cpu_flags;
               end
               // (RL8) flags cleared only after they are saved
               PPIC_STEP_CLEAR_FLAGS:
               begin
                  r_next.flag_clear = 1'b1;
               end
               // (RL9) upper byte zero, lower byte is the vector
               PPIC_STEP_LOAD_PC:
               begin
                  r_next.pc_load = 1'b1;
                  r_next.pc_value = {8'h00,
                     8'({3'h0, r_reg.win_prio} << PPIC_VECTOR_SHIFT)};
               end
               default:
               begin
                  r_next.stack_push = 1'b0;
               end
            endcase
            // (RL12) busy for 12 cycles, one fewer than the thirteen of the dispatch part of latency
            if (r_reg.step == PPIC_STEP_LAST)
            begin
               r_next.state = PPIC_ST_IDLE;
               r_next.step = 4'h0;
            end
            else
            begin
               r_next.step = r_reg.step + 4'h1;
            end
         end
         default:
         begin
            r_next.state = PPIC_ST_IDLE;
            r_next.step = 4'h0;
         end
      endcase

      // (RL1) hardware events win over any clear in the same cycle
      for (int i = 0; i < PPIC_NUM_CLR; i++)
      begin
         // (RL23) reserved bits never set
         r_next.posted[i] = r_next.posted[i]
                            | (set_evt[i] & PPIC_CLR_IMPL[i]);
      end
   end

   always_ff @(posedge mclk)
   begin
      // (RL23) everything starts at zero
      if (!rst_n)
      begin
         r_reg <= PPIC_REGS_RESET;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

endmodule : ppic_ctrl

// ---- ppic_core_model.sv ----
`timescale 1ns/10ps
module ppic_core_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic gie_set,
   input wire logic flag_clear,
   input wire logic pc_load,
   input wire logic [15:0] pc_load_value,
   output logic global_int_enable,
   output logic instr_boundary,
   output logic [15:0] cpu_program_counter,
   output logic [7:0] cpu_flags
);
   logic [1:0] cnt_reg;
   logic gie_reg;
   logic [15:0] pc_reg;
   assign global_int_enable = gie_reg;
   assign instr_boundary = (cnt_reg == 2'h2);
   assign cpu_program_counter = pc_reg;
   assign cpu_flags = {gie_reg, 7'h05};
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         cnt_reg <= 2'h0;
         gie_reg <= 1'b0;
         pc_reg <= 16'h3a5c;
      end
      else
      begin
         cnt_reg <= (cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
         if (flag_clear)
            gie_reg <= 1'b0;
         else if (gie_set)
            gie_reg <= 1'b1;
         if (pc_load)
            pc_reg <= pc_load_value;
      end
   end
endmodule : ppic_core_model

// ---- ppic_ctrl_monitor.sv ----
`timescale 1ns/10ps
module ppic_ctrl_monitor (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic global_int_enable,
   input wire logic instr_boundary,
   input wire logic [15:0] cpu_program_counter,
   input wire logic [7:0] cpu_flags,
   input wire logic irq_active,
   input wire logic dispatch_busy,
   input wire logic stack_push,
   input wire logic [7:0] stack_data,
   input wire logic flag_clear,
   input wire logic pc_load,
   input wire logic [15:0] pc_load_value
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
   property p_rsv0;
      $past(reg_rd) && $past(reg_addr) == 8'hda |-> reg_rdata[1] == 1'b0;
   endproperty
   a_rsv0: assert property (p_rsv0) else $error("reserved bit set");
   property p_rsv1;
      $past(reg_rd) && $past(reg_addr) == 8'hdb
         |-> (reg_rdata & 8'h9f) == 8'h00;
   endproperty
   a_rsv1: assert property (p_rsv1) else $error("reserved bit set");
   property p_rsv2;
      $past(reg_rd) && $past(reg_addr) == 8'hdc
         |-> (reg_rdata & 8'he9) == 8'h00;
   endproperty
   a_rsv2: assert property (p_rsv2) else $error("reserved bit set");
   // no take may start while the core has interrupts off
   property p_gate;
      !global_int_enable && !dispatch_busy |=> !dispatch_busy;
   endproperty
   a_gate: assert property (p_gate) else $error("irq while off");
   property p_take;
      instr_boundary && irq_active && !dispatch_busy |=> dispatch_busy;
   endproperty
   a_take: assert property (p_take) else $error("no dispatch");
   property p_len;
      $rose(dispatch_busy) |-> dispatch_busy[*8] ##1 dispatch_busy[*4]
         ##1 !dispatch_busy;
   endproperty
   a_len: assert property (p_len) else $error("dispatch length");
   property p_order;
      $rose(dispatch_busy) |-> ##1 stack_push
         && stack_data == cpu_program_counter[15:8] ##1 stack_push
         && stack_data == cpu_program_counter[7:0] ##1 stack_push
         && stack_data == cpu_flags ##1 flag_clear ##1 pc_load;
   endproperty
   a_order: assert property (p_order) else $error("push order");
   property p_vec;
      pc_load |-> pc_load_value[15:8] == 8'h00 && pc_load_value[1:0] == 2'h0
         && pc_load_value[7:2] <= 6'h19;
   endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
endmodule : ppic_ctrl_monitor
bind ppic_ctrl ppic_ctrl_monitor mon_u (.mclk, .rst_n, .reg_addr, .reg_rd,
   .reg_rdata, .global_int_enable, .instr_boundary, .cpu_program_counter,
   .cpu_flags, .irq_active, .dispatch_busy, .stack_push, .stack_data,
   .flag_clear, .pc_load, .pc_load_value);

// ---- ppic_ctrl_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
   err_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module ppic_ctrl_tb_top
   import ppic_pkg::*;
;
   logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, gie_set = 0;
   logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, stack_data;
   logic [7:0] cpu_flags;
   logic [6:0] ev = '0, v;
   logic [4:0] pin = '0;
   logic [7:0] pm [3];
   logic [7:0] mm [3];
   logic [7:0] impl [3] = '{8'hfd, 8'h60, 8'h16};
   logic irq_active, dispatch_busy, stack_push, flag_clear, pc_load;
   logic global_int_enable, instr_boundary;
   logic [15:0] pc_load_value, cpu_program_counter;
   int err_count = 0, check_count = 0, cyc = 0;
   int er [7] = '{0, 0, 0, 0, 1, 1, 2};
   int eb [7] = '{0, 2, 3, 6, 5, 6, 1};
   int pr [5] = '{0, 0, 2, 0, 2};
   int pb [5] = '{4, 7, 4, 5, 2};
   ppic_ctrl dut_u (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .gpio_port0_cond(pin[0]), .gpio_port1_cond(pin[1]),
      .gpio_port2_cond(pin[2]), .ext_line_one(pin[3]), .ext_line_two(pin[4]),
      .power_on_low_voltage(ev[0]), .spi_tx_empty_evt(ev[1]),
      .spi_rx_full_evt(ev[2]), .sleep_timer_evt(ev[3]), .timer_1ms_evt(ev[4]),
      .interval_timer_evt(ev[5]), .free_counter_wrap_evt(ev[6]),
      .global_int_enable, .instr_boundary, .cpu_program_counter, .cpu_flags,
      .irq_active, .dispatch_busy, .stack_push, .stack_data, .flag_clear,
      .pc_load, .pc_load_value);
   ppic_core_model core_u (.mclk, .rst_n, .gie_set, .flag_clear, .pc_load,
      .pc_load_value, .global_int_enable, .instr_boundary,
      .cpu_program_counter, .cpu_flags);
   initial forever #20 mclk = ~mclk;
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   // a hang still ends in the single report
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_count++;
         close_out();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK("read data", e, reg_rdata)
   endtask : rd
   task automatic chk_all();
      for (int r = 0; r < 3; r++)
         rd(PPIC_CLR_ADDR[r], pm[r]);
   endtask : chk_all
   task automatic wr_all(input logic [7:0] d);
      for (int r = 0; r < 3; r++)
         wr(PPIC_CLR_ADDR[r], d);
   endtask : wr_all
   // pc_load is a one-cycle pulse, so look just after each edge
   task automatic wait_load();
      for (int i = 0; i < 40 && pc_load !== 1'b1; i++)
      begin
         @(posedge mclk);
         #1;
      end
   endtask : wait_load
   // lowest pending number wins; gie pulse stands in for a return
   task automatic take();
      int best;
      int br;
      int bb;
      best = 99;
      br = 0;
      bb = 0;
      for (int r = 0; r < 3; r++)
         for (int b = 0; b < 8; b++)
            if (pm[r][b] && mm[r][b] && PPIC_PRIO_OF[r][b] < best)
            begin
               best = PPIC_PRIO_OF[r][b];
               br = r;
               bb = b;
            end
      `CHK("irq while off", 1'b0, irq_active)
      @(posedge mclk);
      gie_set <= 1'b1;
      @(posedge mclk);
      gie_set <= 1'b0;
      wait_load();
      `CHK("pc load", 1'b1, pc_load)
      `CHK("vector", 16'(best * 4), pc_load_value)
      pm[br][bb] = 1'b0;
   endtask : take
   initial
   begin
      pm = '{default: 8'h00};
      mm = '{default: 8'h00};
      void'($urandom(12699));
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      chk_all();
      for (int m = 0; m < 4; m++)
         rd(PPIC_MASK_ADDR[m], 8'h00);
      repeat (6)
      begin
         v = 7'($urandom);
         @(posedge mclk);
         ev <= v;
         @(posedge mclk);
         ev <= 7'h00;
         for (int i = 0; i < 7; i++)
            if (v[i])
               pm[er[i]][eb[i]] = 1'b1;
         chk_all();
      end
      wr_all(8'h00);
      pm = '{default: 8'h00};
      pin <= 5'h1f;
      repeat (6) @(posedge mclk);
      for (int i = 0; i < 5; i++)
         pm[pr[i]][pb[i]] = 1'b1;
      chk_all();
      wr_all(8'h00);
      pm = '{default: 8'h00};
      repeat (6) @(posedge mclk);
      chk_all();
      pin <= 5'h00;
      wr(PPIC_MASK_ADDR[3], 8'h80);
      rd(PPIC_MASK_ADDR[3], 8'h80);
      wr_all(8'hff);
      pm = impl;
      chk_all();
      wr_all(8'h00);
      chk_all();
      wr(PPIC_MASK_ADDR[3], 8'h00);
      wr(PPIC_CLR_ADDR[0], 8'h0f);
      wr_all(8'hff);
      pm[0] = 8'h0d;
      chk_all();
      wr_all(8'h00);
      pm = impl;
      pm[0] = 8'h00;
      wr(PPIC_MASK_ADDR[3], 8'h80);
      wr_all(8'hff);
      wr(PPIC_MASK_ADDR[3], 8'h00);
      pm = impl;
      // random masks first, then all open
      for (int k = 0; k < 2; k++)
      begin
         for (int r = 0; r < 3; r++)
         begin
            mm[r] = (k == 1) ? 8'hff : 8'($urandom);
            wr(PPIC_MASK_ADDR[r], mm[r]);
            rd(PPIC_MASK_ADDR[r], mm[r] & PPIC_MASK_WR[r]);
         end
         while (|((pm[0] & mm[0]) | (pm[1] & mm[1]) | (pm[2] & mm[2])))
            take();
         chk_all();
      end
      // event arriving while enabled and unmasked is taken at once
      @(posedge mclk);
      gie_set <= 1'b1;
      @(posedge mclk);
      gie_set <= 1'b0;
      @(posedge mclk);
      ev <= 7'h01;
      @(posedge mclk);
      ev <= 7'h00;
      wait_load();
      `CHK("pc load", 1'b1, pc_load)
      `CHK("vector", 16'(PPIC_PRIO_OF[0][0] * 4), pc_load_value)
      chk_all();
      close_out();
   end
endmodule : ppic_ctrl_tb_top
